// [common/ipa_evt_if.sv]
interface ipa_evt_if;
  logic [16:0] rise;
  logic [16:0] enter_oh;
  logic [16:0] exit_oh;
  logic [16:0] active;

  modport src (output rise);
  modport trk (input enter_oh, input exit_oh, output active);
  modport top (input rise, input active, output enter_oh, output exit_oh);
endinterface : ipa_evt_if

// [common/ipa_pkg.sv]
// ----------------------------------------------------------------------------
// Summary of operation
// - writing one to a pend-set bit marks that source pending
// - zeros written to pend-set leave pending state untouched
// - writing one to a pend-clear bit removes that source's pending state
// - zeros written to pend-clear leave pending state untouched
// - active status bit is one while the core services that source
// - bits 0-7: timer one, timer two, management, baseband, sleep, serial one, two, security
// - bits 8-11: mac timer, mac transmit, mac receive, adc
// - bits 12-15 external lines a to d; bit 16 debug
// - pend-set at 0xE000E200, pend-clear at 0xE000E280, active at 0xE000E300
// ----------------------------------------------------------------------------
package ipa_pkg;

  localparam int unsigned IPA_NSRC = 17;
  localparam int unsigned IPA_IDW = 5;
  localparam int unsigned IPA_NEVT = 4;

  // register byte addresses
  localparam logic [31:0] IPA_PEND_SET_ADDR = 32'hE000_E200;
  localparam logic [31:0] IPA_PEND_CLEAR_ADDR = 32'hE000_E280;
  localparam logic [31:0] IPA_ACTIVE_ADDR = 32'hE000_E300;
  localparam logic [31:0] IPA_EVT_STATUS_ADDR = 32'hE000_E400;
  localparam logic [31:0] IPA_EVT_CLEAR_ADDR = 32'hE000_E404;
  localparam logic [31:0] IPA_EVT_ENABLE_ADDR = 32'hE000_E408;

  // reset values
  localparam logic [16:0] IPA_PEND_RST = 17'h0_0000;
  localparam logic [16:0] IPA_ACTIVE_RST = 17'h0_0000;
  localparam logic [3:0] IPA_EVT_RST = 4'h0;
  localparam logic [3:0] IPA_EVT_EN_RST = 4'h0;
  localparam logic [31:0] IPA_RDATA_RST = 32'h0000_0000;

  // source bit positions
  localparam int unsigned IPA_SRC_TIMER_ONE = 0;
  localparam int unsigned IPA_SRC_TIMER_TWO = 1;
  localparam int unsigned IPA_SRC_MANAGEMENT = 2;
  localparam int unsigned IPA_SRC_BASEBAND = 3;
  localparam int unsigned IPA_SRC_SLEEP_TIMER = 4;
  localparam int unsigned IPA_SRC_SERIAL_CTRL_ONE = 5;
  localparam int unsigned IPA_SRC_SERIAL_CTRL_TWO = 6;
  localparam int unsigned IPA_SRC_SECURITY = 7;
  localparam int unsigned IPA_SRC_MAC_TIMER = 8;
  localparam int unsigned IPA_SRC_MAC_TRANSMIT = 9;
  localparam int unsigned IPA_SRC_MAC_RECEIVE = 10;
  localparam int unsigned IPA_SRC_ADC = 11;
  localparam int unsigned IPA_SRC_EXTERNAL_LINE_A = 12;
  localparam int unsigned IPA_SRC_EXTERNAL_LINE_B = 13;
  localparam int unsigned IPA_SRC_EXTERNAL_LINE_C = 14;
  localparam int unsigned IPA_SRC_EXTERNAL_LINE_D = 15;
  localparam int unsigned IPA_SRC_DEBUG = 16;

  // sources that arrive on pins and need synchronising
  localparam logic [16:0] IPA_PIN_SRC_MASK = 17'h0_F000;

  // event status bits
  localparam int unsigned IPA_EVT_MISS = 0;
  localparam int unsigned IPA_EVT_ENTER = 1;
  localparam int unsigned IPA_EVT_EXIT = 2;
  localparam int unsigned IPA_EVT_BAD_ADDR = 3;

  localparam logic [1:0] IPA_RESP_OKAY = 2'h0;
  localparam logic [1:0] IPA_RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    IPA_SEL_NONE = 3'b000,
    IPA_SEL_PEND_SET = 3'b001,
    IPA_SEL_PEND_CLEAR = 3'b010,
    IPA_SEL_ACTIVE = 3'b011,
    IPA_SEL_EVT_STATUS = 3'b100,
    IPA_SEL_EVT_CLEAR = 3'b101,
    IPA_SEL_EVT_ENABLE = 3'b110
  } ipa_sel_t;

  typedef enum logic {
    IPA_BUS_IDLE = 1'b0,
    IPA_BUS_ACK = 1'b1
  } ipa_bus_t;

  // one-hot source vector from a core-supplied source number
  function automatic logic [16:0] ipa_onehot(input logic [4:0] id, input logic vld);
    logic [16:0] r;
    r = IPA_PEND_RST;
    for (int i = 0; i < IPA_NSRC; i++) begin
      r[i] = vld && (id == i[4:0]);
    end
    return r;
  endfunction : ipa_onehot

endpackage : ipa_pkg

// [hdl/ipa_act_trk.sv]
module ipa_act_trk import ipa_pkg::*; (
  input wire logic i_ref_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  ipa_evt_if.trk evt // entry and exit in, active out
);

  typedef struct packed {
    logic [16:0] active;
  } ipa_trk_st_t;

  ipa_trk_st_t st_r;
  ipa_trk_st_t st_nxt;

  // entry wins over an exit of the same source
  always_comb begin
    st_nxt = st_r;
    st_nxt.active = (st_r.active & ~evt.exit_oh) | evt.enter_oh;
  end

  assign evt.active = st_r.active;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r.active <= IPA_ACTIVE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : ipa_act_trk

// [hdl/ipa_src_sync.sv]
module ipa_src_sync import ipa_pkg::*; (
  input wire logic i_ref_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic [16:0] i_src_req, // source request levels
  ipa_evt_if.src evt // rising edges out
);

  typedef struct packed {
    logic [16:0] meta;
    logic [16:0] sync;
    logic [16:0] prev;
  } ipa_sync_st_t;

  ipa_sync_st_t st_r;
  ipa_sync_st_t st_nxt;
  logic [16:0] lvl;

  // pin lines take two flops, on-chip sources none
  for (genvar g = 0; g < IPA_NSRC; g++) begin : g_lvl
    if (IPA_PIN_SRC_MASK[g]) begin : g_pin
      assign lvl[g] = st_r.sync[g];
    end else begin : g_int
      assign lvl[g] = i_src_req[g];
    end
  end

  always_comb begin
    st_nxt = st_r;
    st_nxt.meta = i_src_req & IPA_PIN_SRC_MASK;
    st_nxt.sync = st_r.meta;
    st_nxt.prev = lvl;
  end

  assign evt.rise = lvl & ~st_r.prev;

  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

endmodule : ipa_src_sync

// [hdl/ipa_top.sv]
// Chosen here: the Avalon-MM register port.
module ipa_top import ipa_pkg::*; (
  input wire logic i_ref_clk, // system clock, 25 MHz
  input wire logic i_nrst, // async reset, active low
  // avalon-mm slave
  input wire logic [31:0] i_avs_address, // byte address
  input wire logic i_avs_read, // read request
  input wire logic i_avs_write, // write request
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // byte lanes
  output logic [31:0] o_avs_readdata, // read data
  output logic o_avs_waitrequest, // low for the answer cycle
  output logic [1:0] o_avs_response, // okay or slave error
  // interrupt sources
  input wire logic [16:0] i_src_req, // request levels, rising edge pends
  // core service signalling
  input wire logic i_core_enter, // core enters a handler, pulse
  input wire logic [4:0] i_core_enter_id, // source number entered
  input wire logic i_core_exit, // core leaves a handler, pulse
  input wire logic [4:0] i_core_exit_id, // source number left
  // status outputs
  output logic [16:0] o_pending, // pending state per source
  output logic [16:0] o_active, // active state per source
  output logic o_irq // enabled event status set
);

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    ipa_bus_t bus;
    logic waitreq;
    logic [31:0] rdata;
    logic [1:0] resp;
    logic [31:0] addr;
    logic wr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [16:0] pend;
    logic [3:0] evt;
    logic [3:0] evt_en;
    logic irq;
  } ipa_top_st_t;

  ipa_top_st_t st_r;
  ipa_top_st_t st_nxt;

  ipa_evt_if evt_if ();

  // --------------------------------------------------------------------------
  // helpers
  // --------------------------------------------------------------------------
  // register select from a byte address
  function automatic ipa_sel_t ipa_decode(input logic [31:0] a);
    ipa_sel_t s;
    s = IPA_SEL_NONE;
    case (a)
      IPA_PEND_SET_ADDR: s = IPA_SEL_PEND_SET;
      IPA_PEND_CLEAR_ADDR: s = IPA_SEL_PEND_CLEAR;
      IPA_ACTIVE_ADDR: s = IPA_SEL_ACTIVE;
      IPA_EVT_STATUS_ADDR: s = IPA_SEL_EVT_STATUS;
      IPA_EVT_CLEAR_ADDR: s = IPA_SEL_EVT_CLEAR;
      IPA_EVT_ENABLE_ADDR: s = IPA_SEL_EVT_ENABLE;
      default: s = IPA_SEL_NONE;
    endcase
    return s;
  endfunction : ipa_decode

  // write data gated by byte enables
  function automatic logic [31:0] ipa_lanes(input logic [31:0] d, input logic [3:0] be);
    logic [31:0] m;
    m = IPA_RDATA_RST;
    for (int i = 0; i < 4; i++) begin
      m[i*8 +: 8] = be[i] ? d[i*8 +: 8] : 8'h00;
    end
    return m;
  endfunction : ipa_lanes

  // --------------------------------------------------------------------------
  // submodules
  // --------------------------------------------------------------------------
  ipa_src_sync u_sync (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .i_src_req(i_src_req),
    .evt(evt_if.src)
  );

  ipa_act_trk u_trk (
    .i_ref_clk(i_ref_clk),
    .i_nrst(i_nrst),
    .evt(evt_if.trk)
  );

  assign evt_if.enter_oh = ipa_onehot(i_core_enter_id, i_core_enter);
  assign evt_if.exit_oh = ipa_onehot(i_core_exit_id, i_core_exit);

  // --------------------------------------------------------------------------
  // next-state logic
  // --------------------------------------------------------------------------
  ipa_sel_t sel_in;
  ipa_sel_t sel_q;
  logic [31:0] wmask;
  logic [16:0] sw_set;
  logic [16:0] sw_clr;
  logic [3:0] evt_clr;
  logic [3:0] evt_new;
  logic bad_wr;

  always_comb begin
    st_nxt = st_r;
    sel_in = ipa_decode(i_avs_address);
    sel_q = ipa_decode(st_r.addr);
    wmask = ipa_lanes(st_r.wdata, st_r.be);
    sw_set = IPA_PEND_RST;
    sw_clr = IPA_PEND_RST;
    evt_clr = IPA_EVT_RST;
    bad_wr = 1'b0;

    case (st_r.bus)
      IPA_BUS_IDLE: begin
        st_nxt.waitreq = 1'b1;
        if (i_avs_read || i_avs_write) begin
          // take the request, answer on the next cycle
          st_nxt.bus = IPA_BUS_ACK;
          st_nxt.waitreq = 1'b0;
          st_nxt.addr = i_avs_address;
          st_nxt.wr = i_avs_write;
          st_nxt.wdata = i_avs_writedata;
          st_nxt.be = i_avs_byteenable;
          st_nxt.resp = (sel_in == IPA_SEL_NONE) ? IPA_RESP_SLVERR : IPA_RESP_OKAY;
          st_nxt.rdata = IPA_RDATA_RST;
          if (!i_avs_write) begin
            case (sel_in)
              IPA_SEL_PEND_SET: st_nxt.rdata[16:0] = st_r.pend;
              IPA_SEL_PEND_CLEAR: st_nxt.rdata[16:0] = st_r.pend;
              IPA_SEL_ACTIVE: st_nxt.rdata[16:0] = evt_if.active;
              IPA_SEL_EVT_STATUS: st_nxt.rdata[3:0] = st_r.evt;
              IPA_SEL_EVT_ENABLE: st_nxt.rdata[3:0] = st_r.evt_en;
              default: st_nxt.rdata = IPA_RDATA_RST;
            endcase
          end
        end
      end
      IPA_BUS_ACK: begin
        // write takes effect on the edge the master sees waitrequest low
        st_nxt.bus = IPA_BUS_IDLE;
        st_nxt.waitreq = 1'b1;
        if (st_r.wr) begin
          case (sel_q)
            IPA_SEL_PEND_SET: sw_set = wmask[16:0];
            IPA_SEL_PEND_CLEAR: sw_clr = wmask[16:0];
            IPA_SEL_EVT_CLEAR: evt_clr = wmask[3:0];
            IPA_SEL_EVT_ENABLE: begin
              for (int i = 0; i < IPA_NEVT; i++) begin
                if (st_r.be[0]) begin
                  st_nxt.evt_en[i] = st_r.wdata[i];
                end
              end
            end
            IPA_SEL_NONE: bad_wr = 1'b1;
            default: bad_wr = 1'b0; // active and status are read-only
          endcase
        end else begin
          bad_wr = (sel_q == IPA_SEL_NONE);
        end
      end
      default: begin
        st_nxt.bus = IPA_BUS_IDLE;
        st_nxt.waitreq = 1'b1;
      end
    endcase

    // pending: source edge wins over any clear in the same cycle
    st_nxt.pend = ((st_r.pend | sw_set) & ~(sw_clr | evt_if.enter_oh))
                  | evt_if.rise;

    // sticky events, set wins over clear
    evt_new = IPA_EVT_RST;
    evt_new[IPA_EVT_MISS] = |(evt_if.rise & st_r.pend);
    evt_new[IPA_EVT_ENTER] = |evt_if.enter_oh;
    evt_new[IPA_EVT_EXIT] = |evt_if.exit_oh;
    evt_new[IPA_EVT_BAD_ADDR] = bad_wr;
    st_nxt.evt = (st_r.evt & ~evt_clr) | evt_new;

    st_nxt.irq = |(st_nxt.evt & st_nxt.evt_en);
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_r.bus <= IPA_BUS_IDLE;
      st_r.waitreq <= 1'b1;
      st_r.rdata <= IPA_RDATA_RST;
      st_r.resp <= IPA_RESP_OKAY;
      st_r.addr <= IPA_RDATA_RST;
      st_r.wr <= 1'b0;
      st_r.wdata <= IPA_RDATA_RST;
      st_r.be <= 4'h0;
      st_r.pend <= IPA_PEND_RST;
      st_r.evt <= IPA_EVT_RST;
      st_r.evt_en <= IPA_EVT_EN_RST;
      st_r.irq <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // --------------------------------------------------------------------------
  // outputs
  // --------------------------------------------------------------------------
  assign o_avs_readdata = st_r.rdata;
  assign o_avs_waitrequest = st_r.waitreq;
  assign o_avs_response = st_r.resp;
  assign o_pending = st_r.pend;
  assign o_active = evt_if.active;
  assign o_irq = st_r.irq;

endmodule : ipa_top

// [tb/ipa_asserts.sv]
module ipa_asserts import ipa_pkg::*; (
  input wire logic i_ref_clk, // clock
  input wire logic i_nrst, // reset
  input wire logic [31:0] i_avs_address, // address
  input wire logic i_avs_read, // read
  input wire logic i_avs_write, // write
  input wire logic [31:0] i_avs_writedata, // write data
  input wire logic [3:0] i_avs_byteenable, // lanes
  input wire logic [31:0] o_avs_readdata, // read data
  input wire logic o_avs_waitrequest, // wait
  input wire logic [1:0] o_avs_response, // response
  input wire logic i_core_enter, // entry
  input wire logic [4:0] i_core_enter_id, // entry id
  input wire logic [16:0] o_pending, // pending
  input wire logic [16:0] o_active // active
);
  logic [16:0] d;
  logic wr, rd, map, s_set, s_clr;
  assign d = i_avs_writedata[16:0] & {i_avs_byteenable[2], {8{i_avs_byteenable[1]}},
    {8{i_avs_byteenable[0]}}};
  assign wr = !o_avs_waitrequest && i_avs_write && !i_core_enter;
  assign rd = !o_avs_waitrequest && i_avs_read;
  assign s_set = i_avs_address == IPA_PEND_SET_ADDR;
  assign s_clr = i_avs_address == IPA_PEND_CLEAR_ADDR;
  assign map = i_avs_address inside {IPA_PEND_SET_ADDR, IPA_PEND_CLEAR_ADDR, IPA_ACTIVE_ADDR,
    IPA_EVT_STATUS_ADDR, IPA_EVT_CLEAR_ADDR, IPA_EVT_ENABLE_ADDR};
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  property p_take; (i_avs_read || i_avs_write) && o_avs_waitrequest |=> !o_avs_waitrequest;
  endproperty
  a_take: assert property (p_take) else $error("request not answered");
  property p_set; wr && s_set |=> (o_pending & $past(d)) == $past(d); endproperty
  a_set: assert property (p_set) else $error("set bit not pending");
  property p_set0; wr && s_set |=> (o_pending & $past(o_pending)) == $past(o_pending);
  endproperty
  a_set0: assert property (p_set0) else $error("set write dropped a bit");
  property p_clr; wr && s_clr |=> (o_pending & $past(d)) == 17'h0_0000; endproperty
  a_clr: assert property (p_clr) else $error("clear bit still pending");
  property p_clr0; wr && s_clr |=> (o_pending & ~$past(d)) == ($past(o_pending) & ~$past(d));
  endproperty
  a_clr0: assert property (p_clr0) else $error("clear write hit zero bit");
  property p_rdp; rd && (s_set || s_clr) |-> o_avs_readdata == {15'h0000, $past(o_pending)};
  endproperty
  a_rdp: assert property (p_rdp) else $error("pending read wrong");
  property p_rda; rd && i_avs_address == IPA_ACTIVE_ADDR |->
    o_avs_readdata == {15'h0000, $past(o_active)}; endproperty
  a_rda: assert property (p_rda) else $error("active read wrong");
  property p_unm; rd && !map |-> o_avs_readdata == 32'h0000_0000 &&
    o_avs_response == IPA_RESP_SLVERR; endproperty
  a_unm: assert property (p_unm) else $error("unmapped read answered");
  property p_ent; i_core_enter && i_core_enter_id < 5'h11 |=> o_active[$past(i_core_enter_id)];
  endproperty
  a_ent: assert property (p_ent) else $error("entered source not active");
  c_set: cover property (wr && s_set);
  c_ent: cover property (i_core_enter);
  c_unm: cover property (rd && !map);
endmodule : ipa_asserts

bind ipa_top ipa_asserts u_chk (.i_ref_clk, .i_nrst, .i_avs_address, .i_avs_read, .i_avs_write,
  .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata, .o_avs_waitrequest, .o_avs_response,
  .i_core_enter, .i_core_enter_id, .o_pending, .o_active);

// [tb/ipa_core_model.sv]
module ipa_core_model (
  input wire logic i_ref_clk, // system clock
  input wire logic i_nrst, // async reset, active low
  input wire logic i_go_enter, // bench asks for a handler entry
  input wire logic i_go_exit, // bench asks for a handler exit
  input wire logic [4:0] i_id, // source number asked for
  output logic o_enter, // entry pulse
  output logic o_exit, // exit pulse
  output logic [4:0] o_enter_id, // entry source number
  output logic [4:0] o_exit_id // exit source number
);
  // ids are bit-inverted every cycle outside a pulse so stale numbers do not hold steady
  always_ff @(posedge i_ref_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_enter <= 1'b0;
      o_exit <= 1'b0;
      o_enter_id <= 5'h00;
      o_exit_id <= 5'h00;
    end else begin
      o_enter <= i_go_enter;
      o_exit <= i_go_exit;
      o_enter_id <= i_go_enter ? i_id : ~o_enter_id;
      o_exit_id <= i_go_exit ? i_id : ~o_exit_id;
    end
  end
endmodule : ipa_core_model

// [tb/irq_pending_active_regs_test.sv]
module irq_pending_active_regs_test import ipa_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_ref_clk, i_nrst, rd, wr, wq, ge, gx, ce, cx, irq;
  logic [31:0] adr, wd, rdat, q, d;
  logic [3:0] be, b;
  logic [1:0] resp, r;
  logic [16:0] src, pend, act, ep;
  logic [4:0] gid, cei, cxi;
  logic [31:0] regs [3] = '{IPA_PEND_SET_ADDR, IPA_PEND_CLEAR_ADDR, IPA_ACTIVE_ADDR};
  logic [31:0] cd [4] = '{32'hFFFF_FFFF, 32'h0000_0000, 32'h0001_0000, 32'hFFFE_FFFF};
  int miscompares, n_compared, cyc, k;
  ipa_top uut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdat),
    .o_avs_waitrequest(wq), .o_avs_response(resp), .i_src_req(src), .i_core_enter(ce),
    .i_core_enter_id(cei), .i_core_exit(cx), .i_core_exit_id(cxi), .o_pending(pend),
    .o_active(act), .o_irq(irq));
  ipa_core_model core (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst), .i_go_enter(ge), .i_go_exit(gx),
    .i_id(gid), .o_enter(ce), .o_exit(cx), .o_enter_id(cei), .o_exit_id(cxi));
  initial begin
    i_ref_clk = 1'b0;
    forever #20 i_ref_clk = ~i_ref_clk;
  end
  task chk(input string n, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask : chk
  task tally_and_finish;
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : tally_and_finish
  // one avalon transfer, held until waitrequest is seen low
  task bus(input logic w, input logic [31:0] a, input logic [31:0] dd, input logic [3:0] bb);
    int n;
    n = 0;
    @(posedge i_ref_clk);
    rd <= !w;
    wr <= w;
    adr <= a;
    wd <= dd;
    be <= bb;
    do begin
      @(posedge i_ref_clk);
      n++;
    end while (wq !== 1'b0 && n < 20);
    q = rdat;
    r = resp;
    rd <= 1'b0;
    wr <= 1'b0;
    if (n == 20) miscompares++;
  endtask : bus
  function automatic logic [16:0] nx(input logic [16:0] p, input logic st,
    input logic [31:0] dd, input logic [3:0] bb);
    logic [16:0] m;
    m = dd[16:0] & {bb[2], {8{bb[1]}}, {8{bb[0]}}};
    return st ? (p | m) : (p & ~m);
  endfunction : nx
  task cyc_go(input logic en);
    @(posedge i_ref_clk);
    ge <= en;
    gx <= !en;
    @(posedge i_ref_clk);
    ge <= 1'b0;
    gx <= 1'b0;
    repeat (3) @(posedge i_ref_clk);
  endtask : cyc_go
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 6000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    {rd, wr, ge, gx, i_nrst} = 5'h00;
    {adr, wd, gid, src, ep} = '0;
    be = 4'hF;
    void'($urandom(51));
    repeat (4) @(posedge i_ref_clk);
    i_nrst <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      bus(1'b0, regs[i], 32'h0000_0000, 4'hF);
      chk("reset value", q, 32'h0000_0000);
    end
    $display("test reset done");
    for (int i = 0; i < 44; i++) begin
      k = (i < 4) ? i % 2 : $urandom_range(1, 0);
      d = (i < 4) ? cd[i] : $urandom;
      b = (i < 4) ? 4'hF : 4'($urandom);
      bus(1'b1, regs[k], d, b);
      ep = nx(ep, k == 0, d, b);
      bus(1'b0, regs[$urandom_range(1, 0)], 32'h0000_0000, 4'hF);
      chk("pending read", q, {15'h0000, ep});
    end
    bus(1'b1, IPA_ACTIVE_ADDR, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, IPA_ACTIVE_ADDR, 32'h0000_0000, 4'hF);
    chk("active read only", q, 32'h0000_0000);
    chk("pending port", {15'h0000, pend}, {15'h0000, ep});
    $display("test set clear done");
    bus(1'b1, IPA_PEND_CLEAR_ADDR, 32'h0001_FFFF, 4'hF);
    for (int i = 0; i < 17; i++) begin
      src[i] <= 1'b1;
      repeat (6) @(posedge i_ref_clk);
      chk("source pend", {15'h0000, pend}, {15'h0000, 17'h0_0001 << i});
      src[i] <= 1'b0;
      gid <= 5'(i);
      cyc_go(1'b1);
      bus(1'b0, IPA_ACTIVE_ADDR, 32'h0000_0000, 4'hF);
      chk("active read", q, {15'h0000, 17'h0_0001 << i});
      cyc_go(1'b0);
      chk("active cleared", {15'h0000, act}, 32'h0000_0000);
    end
    $display("test sources done");
    bus(1'b1, IPA_PEND_SET_ADDR, 32'h0000_0001, 4'hF);
    src[0] <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    src[0] <= 1'b0;
    bus(1'b0, IPA_EVT_STATUS_ADDR, 32'h0000_0000, 4'hF);
    chk("event entry exit miss", q, 32'h0000_0007);
    chk("pending kept on miss", {15'h0000, pend}, 32'h0000_0001);
    bus(1'b1, IPA_PEND_CLEAR_ADDR, 32'h0000_0001, 4'hF);
    bus(1'b1, IPA_EVT_CLEAR_ADDR, 32'h0000_000F, 4'hF);
    bus(1'b1, IPA_EVT_ENABLE_ADDR, 32'h0000_0000, 4'hF);
    bus(1'b1, 32'hE000_E204, 32'hFFFF_FFFF, 4'hF);
    bus(1'b0, 32'hE000_E284, 32'h0000_0000, 4'hF);
    chk("unmapped data", q, 32'h0000_0000);
    chk("unmapped response", {30'h0000_0000, r}, {30'h0000_0000, IPA_RESP_SLVERR});
    chk("unmapped write", {15'h0000, pend}, 32'h0000_0000);
    chk("irq masked", {31'h0000_0000, irq}, 32'h0000_0000);
    bus(1'b1, IPA_EVT_ENABLE_ADDR, 32'h0000_0008, 4'hF);
    bus(1'b0, IPA_EVT_STATUS_ADDR, 32'h0000_0000, 4'hF);
    chk("event status", q, 32'h0000_0008);
    chk("irq raised", {31'h0000_0000, irq}, 32'h0000_0001);
    bus(1'b1, IPA_EVT_CLEAR_ADDR, 32'h0000_0008, 4'hF);
    bus(1'b0, IPA_EVT_STATUS_ADDR, 32'h0000_0000, 4'hF);
    chk("event cleared", {31'h0000_0000, irq}, 32'h0000_0000);
    chk("event status cleared", q, 32'h0000_0000);
    $display("test events done");
    tally_and_finish();
  end
endmodule : irq_pending_active_regs_test
